// file: rtl/dcr_pkg.sv
// Contract
// R01 - Control bits 7:6 pick the minimum switching pulse: none, 20 ns, 40 ns or 80 ns.
// R02 - Control bit 5 at 0 selects the large switches and at 1 the small switches.
// R03 - Software always writes zero to reserved control bit 4.
// R04 - Control bit 3 at 1 aligns ADC tracking to the quiet interval and locks the SAR clock.
// R05 - Software sets the five-bit ADC clock-divide field to zero when enabling sync.
// R06 - Control bits 2:0 pick 1.8, 1.9, 2.0, 2.1, 2.4, 2.7, 3.0 or 3.3 V as target.
// R07 - The control register sits at special-function address 0x97 on page 0x0.
// R08 - The configuration register sits at address 0x96 on page 0x0, all bits read-write.
// R09 - On the system clock path bits 6:5 divide by 1, 2, 4 or 8; ignored on the oscillator.
// R10 - Configuration bit 0 at 0 clocks the converter from its local oscillator, else sysclk.
// R11 - In sleep with the converter on, bit 1 at 0 ties the rail to battery, at 1 floats it.
// R12 - With sync on, bit 4 at 0 inverts the derived SAR clock, at 1 leaves it; else ignored.
// R13 - Reset loads control with 0x21 and configuration with 0x00; writes read back unchanged.
package dcr_pkg;
  // ==========================================================
  // register map (index, byte address is four times the index)
  localparam logic [9:0] IDX_CONFIG = 10'h096;
  localparam logic [9:0] IDX_CONTROL = 10'h097;
  localparam logic [9:0] IDX_STATUS = 10'h098;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h21;
  // ==========================================================
  // control fields
  localparam int CTL_MIN_PULSE_WIDTH_SEL_HI = 7;
  localparam int CTL_MIN_PULSE_WIDTH_SEL_LO = 6;
  localparam int CTL_SWITCH_SIZE_SEL = 5;
  localparam int CTL_RSVD = 4;
  localparam int CTL_SYNC = 3;
  localparam int CTL_OUT_VOLTAGE_SEL_HI = 2;
  localparam int CTL_OUT_VOLTAGE_SEL_LO = 0;
  // ==========================================================
  // configuration fields
  localparam int CFG_LOWBIAS = 7;
  localparam int CFG_DIV_HI = 6;
  localparam int CFG_DIV_LO = 5;
  localparam int CFG_SARINV = 4;
  localparam int CFG_SYSCLK_INVERT = 3;
  localparam int CFG_PEAK_CURRENT_THRESH = 2;
  localparam int CFG_FLOAT = 1;
  localparam int CFG_CONV_CLK_SOURCE_SEL = 0;
  // ==========================================================
  // timing
  localparam int CLK_MHZ = 250;
  localparam int MIN_PULSE_WIDTH_SEL_A_NS = 20;
  localparam int MIN_PULSE_WIDTH_SEL_B_NS = 40;
  localparam int MIN_PULSE_WIDTH_SEL_C_NS = 80;
  // least times round up
  localparam int MIN_PULSE_WIDTH_SEL_A_CYC = (MIN_PULSE_WIDTH_SEL_A_NS * CLK_MHZ + 999) / 1000;
  localparam int MIN_PULSE_WIDTH_SEL_B_CYC = (MIN_PULSE_WIDTH_SEL_B_NS * CLK_MHZ + 999) / 1000;
  localparam int MIN_PULSE_WIDTH_SEL_C_CYC = (MIN_PULSE_WIDTH_SEL_C_NS * CLK_MHZ + 999) / 1000;
  // target voltages in millivolts
  localparam logic [11:0] VOUT_0 = 12'h708;
  localparam logic [11:0] VOUT_1 = 12'h76C;
  localparam logic [11:0] VOUT_2 = 12'h7D0;
  localparam logic [11:0] VOUT_3 = 12'h834;
  localparam logic [11:0] VOUT_4 = 12'h960;
  localparam logic [11:0] VOUT_5 = 12'hA8C;
  localparam logic [11:0] VOUT_6 = 12'hBB8;
  localparam logic [11:0] VOUT_7 = 12'hCE4;
endpackage

// file: rtl/dcr_top.sv
`timescale 1ns/1ps
module dcr_top (
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic LOCAL_OSC_I,
  input wire logic CONV_EN_I,
  input wire logic SLEEP_I,
  output logic [7:0] MIN_PULSE_CYC_O,
  output logic SWITCH_SMALL_O,
  output logic [11:0] VOUT_MV_O,
  output logic ADC_SYNC_EN_O,
  output logic ADC_TRACK_O,
  output logic ADC_SAR_CLK_O,
  output logic CONV_TICK_O,
  output logic CONV_CLK_O,
  output logic RAIL_TIE_VBAT_O,
  output logic RAIL_FLOAT_O,
  output logic LOW_BIAS_EN_O,
  output logic PEAK_CURRENT_THRESH_O
);
  import dcr_pkg::*;

  // ==========================================================
  // decode functions
  function automatic logic [7:0] min_pulse_cycles(input logic [1:0] sel);
    logic [7:0] c;
    c = 8'h00;
    case (sel)
      2'h1: c = 8'(MIN_PULSE_WIDTH_SEL_A_CYC);
      2'h2: c = 8'(MIN_PULSE_WIDTH_SEL_B_CYC);
      2'h3: c = 8'(MIN_PULSE_WIDTH_SEL_C_CYC);
      default: c = 8'h00;
    endcase
    return c;
  endfunction

  function automatic logic [11:0] vout_mv(input logic [2:0] sel);
    logic [11:0] v;
    v = VOUT_0;
    case (sel)
      3'h1: v = VOUT_1;
      3'h2: v = VOUT_2;
      3'h3: v = VOUT_3;
      3'h4: v = VOUT_4;
      3'h5: v = VOUT_5;
      3'h6: v = VOUT_6;
      3'h7: v = VOUT_7;
      default: v = VOUT_0;
    endcase
    return v;
  endfunction

  function automatic logic [2:0] div_last(input logic [1:0] code);
    logic [2:0] d;
    d = 3'h0;
    case (code)
      2'h1: d = 3'h1;
      2'h2: d = 3'h3;
      2'h3: d = 3'h7;
      default: d = 3'h0;
    endcase
    return d;
  endfunction

  // ==========================================================
  // registers
  logic [7:0] conv_control_reg_ff;
  logic [7:0] conv_config_reg_ff;
  logic [31:0] prdata_ff;
  logic slverr_ff;

  // ==========================================================
  // apb decode
  logic [9:0] word_idx;
  logic addr_aligned;
  logic hit_control;
  logic hit_config;
  logic hit_status;
  logic mapped;
  logic setup_phase;
  logic wr_access;
  logic wr_lane0;
  logic [7:0] status_word;
  logic [7:0] rd_byte;

  assign word_idx = PADDR_I[11:2];
  assign addr_aligned = (PADDR_I[1:0] == 2'h0);
  assign hit_control = addr_aligned && (word_idx == IDX_CONTROL); // R07
  assign hit_config = addr_aligned && (word_idx == IDX_CONFIG); // R08
  assign hit_status = addr_aligned && (word_idx == IDX_STATUS);
  assign mapped = hit_control || hit_config || hit_status;
  assign setup_phase = PSEL_I && !PENABLE_I;
  assign wr_access = PSEL_I && PENABLE_I && PWRITE_I && !slverr_ff;
  assign wr_lane0 = wr_access && PSTRB_I[0];
  assign rd_byte = hit_control ? conv_control_reg_ff :
                   hit_config ? conv_config_reg_ff :
                   hit_status ? status_word : 8'h00;

  // reserved bit 4 is stored as written; software keeps it zero
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      conv_control_reg_ff <= RST_CONTROL; // R13
    end else if (wr_lane0 && hit_control) begin
      conv_control_reg_ff <= PWDATA_I[7:0]; // R03
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      conv_config_reg_ff <= RST_CONFIG; // R13
    end else if (wr_lane0 && hit_config) begin
      conv_config_reg_ff <= PWDATA_I[7:0]; // R08
    end
  end

  // read data is captured in the setup cycle
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      prdata_ff <= 32'h0;
    end else if (setup_phase) begin
      prdata_ff <= {24'h0, rd_byte}; // R13
    end
  end

  // error flag: unmapped, unaligned or a write to status
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      slverr_ff <= 1'b0;
    end else if (setup_phase) begin
      slverr_ff <= !mapped || (PWRITE_I && hit_status);
    end
  end

  assign PRDATA_O = prdata_ff;
  assign PREADY_O = PSEL_I && PENABLE_I;
  assign PSLVERR_O = PSEL_I && PENABLE_I && slverr_ff;

  // ==========================================================
  // field views
  logic sync_on;
  logic use_sysclk;
  logic [1:0] div_code;
  assign sync_on = conv_control_reg_ff[CTL_SYNC];
  assign use_sysclk = conv_config_reg_ff[CFG_CONV_CLK_SOURCE_SEL]; // R10
  assign div_code = conv_config_reg_ff[CFG_DIV_HI:CFG_DIV_LO];

  // ==========================================================
  // local oscillator synchroniser
  logic osc_meta_ff;
  logic osc_sync_ff;
  logic osc_prev_ff;
  logic osc_rise;

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      osc_meta_ff <= 1'b0;
      osc_sync_ff <= 1'b0;
      osc_prev_ff <= 1'b0;
    end else begin
      osc_meta_ff <= LOCAL_OSC_I;
      osc_sync_ff <= osc_meta_ff;
      osc_prev_ff <= osc_sync_ff;
    end
  end
  assign osc_rise = osc_sync_ff && !osc_prev_ff;

  // ==========================================================
  // converter clock divider
  logic [2:0] div_cnt_ff;
  logic [2:0] nxt_div_cnt;
  logic div_wrap;
  logic conv_tick;
  logic conv_phase_ff;
  logic tick_ff;

  assign div_wrap = (div_cnt_ff >= div_last(div_code)); // R09
  assign nxt_div_cnt = (!use_sysclk || div_wrap) ? 3'h0 : 3'(div_cnt_ff + 3'h1);
  assign conv_tick = use_sysclk ? div_wrap : osc_rise; // R10

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      div_cnt_ff <= 3'h0;
    end else begin
      div_cnt_ff <= nxt_div_cnt; // R09
    end
  end

  // converter clock level toggles on each tick
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      conv_phase_ff <= 1'b0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= conv_tick;
      if (conv_tick) begin
        conv_phase_ff <= !conv_phase_ff;
      end
    end
  end

  // ==========================================================
  // derived outputs
  logic conv_clk_lvl;
  logic sar_lvl;
  logic track_lvl;
  logic sleeping_on;
  logic [7:0] min_cyc_ff;
  logic small_ff;
  logic [11:0] vout_ff;
  logic sync_ff;
  logic track_ff;
  logic sar_ff;
  logic clk_ff;
  logic tie_ff;
  logic float_ff;
  logic lowbias_ff;
  logic peak_current_thresh_ff;

  // sysclk inversion only matters on the sysclk path
  assign conv_clk_lvl = conv_phase_ff ^ (use_sysclk && conv_config_reg_ff[CFG_SYSCLK_INVERT]);
  // sar clock follows the converter cycle, inverted when bit 4 is low
  assign sar_lvl = sync_on && (conv_clk_lvl ^ !conv_config_reg_ff[CFG_SARINV]); // R12
  // tracking lands in the switch-off half of the cycle
  assign track_lvl = sync_on && !conv_clk_lvl; // R04
  assign sleeping_on = SLEEP_I && CONV_EN_I;

  // control decode
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      min_cyc_ff <= 8'h00;
      small_ff <= 1'b0;
      vout_ff <= VOUT_0;
      sync_ff <= 1'b0;
    end else begin
      min_cyc_ff <= min_pulse_cycles(conv_control_reg_ff[CTL_MIN_PULSE_WIDTH_SEL_HI:CTL_MIN_PULSE_WIDTH_SEL_LO]); // R01
      small_ff <= conv_control_reg_ff[CTL_SWITCH_SIZE_SEL]; // R02
      vout_ff <= vout_mv(conv_control_reg_ff[CTL_OUT_VOLTAGE_SEL_HI:CTL_OUT_VOLTAGE_SEL_LO]); // R06
      sync_ff <= sync_on; // R04
    end
  end

  // adc timing follows the converter clock level
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      track_ff <= 1'b0;
      sar_ff <= 1'b0;
      clk_ff <= 1'b0;
    end else begin
      track_ff <= track_lvl; // R04
      sar_ff <= sar_lvl; // R12
      clk_ff <= conv_clk_lvl;
    end
  end

  // sleep rail connection
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      tie_ff <= 1'b0;
      float_ff <= 1'b0;
    end else begin
      tie_ff <= sleeping_on && !conv_config_reg_ff[CFG_FLOAT]; // R11
      float_ff <= sleeping_on && conv_config_reg_ff[CFG_FLOAT]; // R11
    end
  end

  // configuration mirrors
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      lowbias_ff <= 1'b0;
      peak_current_thresh_ff <= 1'b0;
    end else begin
      lowbias_ff <= conv_config_reg_ff[CFG_LOWBIAS];
      peak_current_thresh_ff <= conv_config_reg_ff[CFG_PEAK_CURRENT_THRESH];
    end
  end

  // ==========================================================
  // status view
  assign status_word = {2'h0, float_ff, tie_ff, track_ff, sar_ff, clk_ff, use_sysclk};

  // ==========================================================
  // output ports
  assign MIN_PULSE_CYC_O = min_cyc_ff;
  assign SWITCH_SMALL_O = small_ff;
  assign VOUT_MV_O = vout_ff;
  assign ADC_SYNC_EN_O = sync_ff;
  assign ADC_TRACK_O = track_ff;
  assign ADC_SAR_CLK_O = sar_ff;
  assign CONV_TICK_O = tick_ff;
  assign CONV_CLK_O = clk_ff;
  assign RAIL_TIE_VBAT_O = tie_ff;
  assign RAIL_FLOAT_O = float_ff;
  assign LOW_BIAS_EN_O = lowbias_ff;
  assign PEAK_CURRENT_THRESH_O = peak_current_thresh_ff;
endmodule

// file: testbench/dcr_checker.sv
`timescale 1ns/1ps
module dcr_checker (
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  input wire logic PSLVERR_O,
  input wire logic SLEEP_I,
  input wire logic CONV_EN_I,
  input wire logic [7:0] MIN_PULSE_CYC_O,
  input wire logic SWITCH_SMALL_O,
  input wire logic [11:0] VOUT_MV_O,
  input wire logic ADC_SYNC_EN_O,
  input wire logic ADC_SAR_CLK_O,
  input wire logic RAIL_TIE_VBAT_O,
  input wire logic RAIL_FLOAT_O
);
  import dcr_pkg::*;
  localparam logic [11:0] VT [8] = '{VOUT_0, VOUT_1, VOUT_2, VOUT_3, VOUT_4, VOUT_5, VOUT_6, VOUT_7};
  localparam logic [7:0] MT [4] = '{8'h00, 8'h05, 8'h0A, 8'h14};
  wire acc = PSEL_I && PENABLE_I;
  wire wr_ctl = acc && PWRITE_I && PSTRB_I[0] && PADDR_I == 12'h25C;
  wire awake = !(SLEEP_I && CONV_EN_I);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // ==========================================================
  // control decode, two cycles after the storing edge
  a_vout_decode: assert property (
    wr_ctl |-> ##2 VOUT_MV_O == VT[$past(PWDATA_I[2:0], 2)]) else $error("vout decode wrong");
  a_min_pulse_width_sel_decode: assert property (
    wr_ctl |-> ##2 MIN_PULSE_CYC_O == MT[$past(PWDATA_I[7:6], 2)]) else $error("min pulse wrong");
  a_switch_size: assert property (
    wr_ctl |-> ##2 SWITCH_SMALL_O == $past(PWDATA_I[5], 2)) else $error("switch size wrong");
  a_sync_follow: assert property (
    wr_ctl |-> ##2 ADC_SYNC_EN_O == $past(PWDATA_I[3], 2)) else $error("sync enable wrong");
  a_sync_gate: assert property (
    !ADC_SYNC_EN_O |-> !ADC_SAR_CLK_O) else $error("sar clock without sync");
  // ==========================================================
  // sleep rail and decoding
  a_rail_cause: assert property (
    RAIL_TIE_VBAT_O || RAIL_FLOAT_O |-> $past(!awake) && !(RAIL_TIE_VBAT_O && RAIL_FLOAT_O))
    else $error("rail state wrong");
  a_rail_awake: assert property (
    awake |=> !RAIL_TIE_VBAT_O && !RAIL_FLOAT_O) else $error("rail set while awake");
  a_unmapped_err: assert property (
    acc && PADDR_I == 12'h300 |-> PSLVERR_O) else $error("unmapped access accepted");
endmodule
bind dcr_top dcr_checker i_chk (.SYS_CLK_I, .SYS_RST_I, .PSEL_I, .PENABLE_I, .PWRITE_I,
  .PADDR_I, .PWDATA_I, .PSTRB_I, .PSLVERR_O, .SLEEP_I, .CONV_EN_I, .MIN_PULSE_CYC_O,
  .SWITCH_SMALL_O, .VOUT_MV_O, .ADC_SYNC_EN_O, .ADC_SAR_CLK_O, .RAIL_TIE_VBAT_O, .RAIL_FLOAT_O);

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import dcr_pkg::*;
  localparam logic [11:0] VT [8] = '{VOUT_0, VOUT_1, VOUT_2, VOUT_3, VOUT_4, VOUT_5, VOUT_6, VOUT_7};
  localparam logic [7:0] MT [4] = '{8'h00, 8'h05, 8'h0A, 8'h14};
  logic SYS_CLK_I, SYS_RST_I, PSEL_I, PENABLE_I, PWRITE_I, LOCAL_OSC_I, CONV_EN_I, SLEEP_I;
  logic [11:0] PADDR_I, VOUT_MV_O;
  logic [31:0] PWDATA_I, PRDATA_O, r, sd;
  logic [3:0] PSTRB_I;
  logic [7:0] MIN_PULSE_CYC_O, d;
  logic PREADY_O, PSLVERR_O, SWITCH_SMALL_O, ADC_SYNC_EN_O, ADC_TRACK_O, ADC_SAR_CLK_O, e;
  logic CONV_TICK_O, CONV_CLK_O, RAIL_TIE_VBAT_O, RAIL_FLOAT_O, LOW_BIAS_EN_O;
  logic PEAK_CURRENT_THRESH_O;
  int failures, n_compared, cnt;
  dcr_top i_dut (.SYS_CLK_I, .SYS_RST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I,
    .PSTRB_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .LOCAL_OSC_I, .CONV_EN_I, .SLEEP_I,
    .MIN_PULSE_CYC_O, .SWITCH_SMALL_O, .VOUT_MV_O, .ADC_SYNC_EN_O, .ADC_TRACK_O, .ADC_SAR_CLK_O,
    .CONV_TICK_O, .CONV_CLK_O, .RAIL_TIE_VBAT_O, .RAIL_FLOAT_O, .LOW_BIAS_EN_O,
    .PEAK_CURRENT_THRESH_O);
  initial begin
    SYS_CLK_I = 1'b0;
    forever #2 SYS_CLK_I = ~SYS_CLK_I;
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    n_compared++;
    if (g !== x) begin
      failures++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic conclude();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge SYS_CLK_I);
    PSEL_I <= 1'b1;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= {24'h0, v};
    @(posedge SYS_CLK_I);
    PENABLE_I <= 1'b1;
    do begin
      @(posedge SYS_CLK_I);
      n++;
    end while (PREADY_O !== 1'b1 && n < 20);
    r = PRDATA_O;
    e = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
    if (n >= 20) begin
      chk(0, 1, "bus timeout");
      conclude();
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge SYS_CLK_I);
    @(negedge SYS_CLK_I);
  endtask
  task automatic ticks(input int c);
    cnt = 0;
    for (int j = 0; j < c; j++) begin
      @(posedge SYS_CLK_I);
      LOCAL_OSC_I <= (j < 48) && (j % 16 >= 8);
      @(negedge SYS_CLK_I);
      if (CONV_TICK_O === 1'b1) cnt++;
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {SYS_RST_I, PSTRB_I} = 5'h1F;
    {PSEL_I, PENABLE_I, PWRITE_I, LOCAL_OSC_I, CONV_EN_I, SLEEP_I, PADDR_I, PWDATA_I} = '0;
    {failures, n_compared} = '0;
    sd = 32'hE406;
    repeat (2) @(posedge SYS_CLK_I);
    SYS_RST_I <= 1'b0;
    apb(0, 12'h25C, 0);
    chk(r, 32'h21, "control reset");
    apb(0, 12'h258, 0);
    chk(r, 32'h0, "config reset");
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      sd = lfsr(sd);
      d = {sd[7:5], 1'b0, sd[3], i[2:0]};
      apb(1, 12'h25C, d);
      apb(0, 12'h25C, 0);
      chk(r, {24'h0, d}, "control readback");
      settle();
      chk(VOUT_MV_O, VT[i], "vout");
      chk(MIN_PULSE_CYC_O, MT[d[7:6]], "min pulse");
      chk(SWITCH_SMALL_O, d[5], "switch");
      chk(ADC_SYNC_EN_O, d[3], "sync");
    end
    $display("control test done");
    for (int i = 0; i < 6; i++) begin
      sd = lfsr(sd);
      d = sd[7:0];
      apb(1, 12'h258, d);
      SLEEP_I <= sd[8] | (i < 2);
      CONV_EN_I <= sd[9] | (i < 2);
      apb(0, 12'h258, 0);
      chk(r, {24'h0, d}, "config readback");
      settle();
      chk(RAIL_TIE_VBAT_O, SLEEP_I & CONV_EN_I & ~d[1], "rail tie");
      chk(RAIL_FLOAT_O, SLEEP_I & CONV_EN_I & d[1], "rail float");
      chk({LOW_BIAS_EN_O, PEAK_CURRENT_THRESH_O}, {d[7], d[2]}, "bias bits");
    end
    $display("config test done");
    for (int k = 0; k < 4; k++) begin
      apb(1, 12'h258, {1'b0, k[1:0], 5'h01});
      settle();
      ticks(64);
      chk(cnt, 64 >> k, "divider");
    end
    apb(1, 12'h258, 8'h60);
    settle();
    ticks(96);
    chk(cnt, 3, "oscillator ticks");
    $display("clock test done");
    apb(1, 12'h25C, 8'h29);
    for (int k = 0; k < 3; k++) begin
      d = (k == 0) ? 8'h61 : (k == 1) ? 8'h71 : 8'h69;
      apb(1, 12'h258, d);
      settle();
      cnt = 0;
      for (int j = 0; j < 17; j++) begin
        @(negedge SYS_CLK_I);
        if (j > 0 && CONV_CLK_O !== e) cnt++;
        e = CONV_CLK_O;
        chk(ADC_SAR_CLK_O, CONV_CLK_O ^ !d[4], "sar clock");
        chk(ADC_TRACK_O, !CONV_CLK_O, "tracking");
      end
      chk(cnt, 2, "converter clock toggles");
    end
    apb(0, 12'h260, 0);
    chk(r[0], 1, "status source");
    apb(1, 12'h260, 8'h3F);
    chk(e, 1, "status write");
    $display("sync test done");
    apb(0, 12'h300, 0);
    chk(r, 0, "unmapped read data");
    chk(e, 1, "unmapped read");
    apb(1, 12'h25C, 8'h21);
    PSTRB_I <= 4'h0;
    apb(1, 12'h25C, 8'hC7);
    PSTRB_I <= 4'hF;
    apb(1, 12'h259, 8'hC7);
    chk(e, 1, "unaligned write");
    apb(0, 12'h25C, 0);
    chk(r, 32'h21, "masked write");
    $display("error test done");
    conclude();
  end
endmodule
